/* File: bench/rdtt_regs_sva.sv */
// port assertions for the register bank
`timescale 1ns/100ps
module rdtt_regs_chk (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dac_enable,
  input wire logic        dac_current_output_oen,
  input wire logic        reference_internal_on,
  input wire logic        reference_input_sel,
  input wire logic        meas_ready,
  input wire logic        precharge_active,
  input wire logic        sense_active,
  input wire logic        touch_sample
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_pre_end;
    precharge_active ##1 !precharge_active;
  endsequence
  a_answer_next: assert property (s_acc |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_unmapped_err: assert property (psel && penable && !pready && paddr == 12'h100
    |=> pslverr && prdata == 32'h0) else $error("unmapped access");
  a_mapped_ok: assert property (psel && penable && !pready && paddr == 12'h00c
    |=> !pslverr) else $error("mapped error");
  a_dac_release: assert property (dac_enable != dac_current_output_oen)
    else $error("dac output state");
  a_ext_ref_off: assert property (!reference_input_sel && !$past(reference_input_sel)
    |-> !reference_internal_on) else $error("internal ref on");
  a_ext_meas: assert property (!reference_input_sel && !$past(reference_input_sel)
    && $past(resetn, 2) |-> meas_ready) else $error("meas blocked");
  a_pre_to_sense: assert property (s_pre_end |-> ##[0:1] sense_active)
    else $error("no sense");
  a_sample_pulse: assert property (touch_sample |=> !touch_sample)
    else $error("sample held");
endmodule : rdtt_regs_chk
bind rdtt_regs rdtt_regs_chk u_chk (.clk, .resetn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .dac_enable, .dac_current_output_oen, .reference_internal_on,
  .reference_input_sel, .meas_ready, .precharge_active, .sense_active, .touch_sample);

/* File: bench/tb.sv */
// self-checking bench for the register bank
`timescale 1ns/100ps
module tb;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic        conv_req = 0, touch_check_req = 0, pready, pslverr, dac_en, oen;
  logic        ref_on, ref_sel, vsel, meas_ready, pre_act, sns_act, t_smp;
  logic [11:0] paddr = 12'h0, a;
  logic [31:0] pwdata = 32'h0, prdata, q, d;
  int          n_fail = 0, comparisons = 0, n, x;
  always #50 clk = ~clk;
  rdtt_regs u_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_req, .touch_check_req, .dac_enable(dac_en),
    .dac_current_output_oen(oen), .reference_internal_on(ref_on),
    .reference_input_sel(ref_sel), .reference_voltage_select(vsel), .meas_ready,
    .precharge_active(pre_act), .sense_active(sns_act), .touch_sample(t_smp));
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, lo);
    end
  endtask : chk_rng
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr_wait(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
    repeat (4) @(posedge clk);
  endtask : wr_wait
  // count cycles while the chosen flag stays at lvl
  task hold(input int s, input logic lvl, output int c);
    c = 0;
    while ((s == 0 ? pre_act : s == 1 ? sns_act : meas_ready) === lvl && c < 40000) begin
      @(posedge clk);
      c++;
    end
  endtask : hold
  function logic [31:0] msk(input logic [11:0] ad);
    case (ad)
      12'h008: return 32'h8000;
      12'h00c: return 32'h001f;
      12'h014: return 32'h003f;
      default: return 32'h0;
    endcase
  endfunction : msk
  function int us_cyc(input int us);
    return us * rdtt_pkg::NS_PER_US / rdtt_pkg::CLK_NS;
  endfunction : us_cyc
  initial begin
    #(100 * 60000);
    n_fail++;
    wrap_up();
  end
  initial begin
    x = $urandom(15973);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0); chk(q, 32'h8000);
    apb(1'b0, 12'h00c, 32'h0); chk(q, 32'h0002);
    apb(1'b0, 12'h014, 32'h0); chk(q, 32'h0);
    chk(oen, 1'b1);
    $display("test reset done");
    for (int k = 0; k < 24; k++) begin
      a = (k % 3 == 0) ? 12'h008 : (k % 3 == 1) ? 12'h00c : (k % 4 == 0 ? 12'h024 : 12'h014);
      d = (k < 3) ? 32'hffff_ffff : $urandom;
      apb(1'b1, a, d);
      apb(1'b0, a, 32'h0);
      chk(q, d & msk(a));
    end
    apb(1'b0, 12'h100, 32'h0); chk({q[30:0], e}, 32'h1);
    $display("test readback done");
    wr_wait(12'h008, 32'h0); chk({dac_en, oen}, 32'h2);
    wr_wait(12'h00c, 32'h11); chk({ref_sel, vsel, ref_on}, 32'h7);
    wr_wait(12'h00c, 32'h03); chk({ref_on, meas_ready}, 32'h1);
    wr_wait(12'h00c, 32'h16); chk(ref_on, 1'b0);
    conv_req <= 1'b1;
    hold(2, 1'b0, n); chk_rng(n, rdtt_pkg::SETTLE1_CYC, rdtt_pkg::SETTLE1_CYC + 8);
    chk(ref_on, 1'b1);
    conv_req <= 1'b0;
    repeat (6) @(posedge clk);
    chk(ref_on, 1'b0);
    apb(1'b0, 12'h020, 32'h0); chk(q, 32'h1);
    $display("test reference done");
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 32'h0000_000f : ($urandom & 32'h0000_000f);
      wr_wait(12'h014, {26'h0, 1'b0, d[1:0], 1'b0, d[3:2]});
      touch_check_req <= 1'b1;
      hold(0, 1'b0, n);
      touch_check_req <= 1'b0;
      x = us_cyc(rdtt_pkg::PRE_US[d[1:0]]);
      hold(0, 1'b1, n); chk_rng(n, x - 1, x + 1);
      if (sns_act !== 1'b1) @(posedge clk);
      x = us_cyc(rdtt_pkg::SENSE_US[d[3:2]]);
      hold(1, 1'b1, n); chk_rng(n, x - 1, x + 1);
      chk(t_smp, 1'b1);
      repeat (8) @(posedge clk);
    end
    $display("test touch done");
    wrap_up();
  end
endmodule : tb

/* File: hdl/rdtt_pkg.sv */
// constants for the reference, dac and touch timing register bank
package rdtt_pkg;
  // printed offsets are not multiples of four: indices, byte address is four times
  localparam logic [7:0]  IDX_DAC       = 8'h02;
  localparam logic [7:0]  IDX_REF       = 8'h03;
  localparam logic [7:0]  IDX_TOUCH     = 8'h05;
  localparam logic [7:0]  IDX_STATUS    = 8'h08;
  localparam logic [7:0]  IDX_CONVERT   = 8'h09;
  localparam logic [9:0]  ADDR_DAC      = {IDX_DAC, 2'b00};
  localparam logic [9:0]  ADDR_REF      = {IDX_REF, 2'b00};
  localparam logic [9:0]  ADDR_TOUCH    = {IDX_TOUCH, 2'b00};
  localparam logic [9:0]  ADDR_STATUS   = {IDX_STATUS, 2'b00};
  localparam logic [9:0]  ADDR_CONVERT  = {IDX_CONVERT, 2'b00};
  // field positions
  localparam int          DAC_PD_BIT    = 15;
  localparam int          INT_BIT       = 4;
  localparam int          SETTLE_LSB    = 2;
  localparam int          REF_PD_BIT    = 1;
  localparam int          REF_VSEL_BIT  = 0;
  localparam int          PRE_LSB       = 3;
  localparam int          SENSE_LSB     = 0;
  // reset values
  localparam logic        DAC_PD_RST    = 1'b1;
  localparam logic        INT_RST       = 1'b0;
  localparam logic [1:0]  SETTLE_RST    = 2'b00;
  localparam logic        REF_PD_RST    = 1'b1;
  localparam logic        REF_VSEL_RST  = 1'b0;
  localparam logic [2:0]  PRE_RST       = 3'h0;
  localparam logic [2:0]  SENSE_RST     = 3'h0;
  // timing
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          NS_PER_US     = 1000;
  localparam int          CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int          SETTLE1_US    = 100;
  localparam int          SETTLE2_US    = 500;
  localparam int          SETTLE3_US    = 1000;
  localparam int          SETTLE1_CYC   = SETTLE1_US * NS_PER_US / CLK_NS;
  localparam int          SETTLE2_CYC   = SETTLE2_US * NS_PER_US / CLK_NS;
  localparam int          SETTLE3_CYC   = SETTLE3_US * NS_PER_US / CLK_NS;
  // precharge and sense times in microseconds (ms figures times 1000)
  localparam int          PRE_US [8]    = '{20, 84, 276, 340, 1044, 1108, 1300, 1364};
  localparam int          SENSE_US [8]  = '{32, 96, 544, 608, 2080, 2144, 2592, 2656};
  localparam int          CW            = 15;
endpackage : rdtt_pkg

/* File: hdl/rdtt_regs.sv */
// reference, dac power and touch timing registers with apb access
`timescale 1ns/100ps
// Notes on behaviour
// - dac off while bit 15 set; reset 1
// - powered-down dac output neither sinks nor sources
// - bit 4: internal 1, external 0
// - settle delay after reference power-up: 0/100/500/1000us
// - bit 1: reference off between conversions
// - external selected keeps internal reference off
// - bit 0: 1.2 V at 0, 2.5 V at 1
// - reference fields read back as written
// - precharge bits 5:3, sense bits 2:0
// - precharge time from field, 20us to 1.364ms
// - sense wait from field, 32us to 2.656ms
module rdtt_regs (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_req,
  input  wire logic        touch_check_req,
  output logic             dac_enable,
  output logic             dac_current_output_oen,
  output logic             reference_internal_on,
  output logic             reference_input_sel,
  output logic             reference_voltage_select,
  output logic             meas_ready,
  output logic             precharge_active,
  output logic             sense_active,
  output logic             touch_sample
);
  typedef enum {RDTT_IDLE, RDTT_SETTLE, RDTT_READY} rdtt_ref_t;
  typedef enum {RDTT_TIDLE, RDTT_PRE, RDTT_SNS} rdtt_tch_t;

  function automatic logic [14:0] rdtt_us_cyc(input int us);
    rdtt_us_cyc = 15'((us * rdtt_pkg::NS_PER_US) / rdtt_pkg::CLK_NS);
  endfunction : rdtt_us_cyc

  function automatic logic rdtt_mapped(input logic [11:0] a);
    rdtt_mapped = (a[11:10] == 2'b00) &&
                  (a[9:0] == rdtt_pkg::ADDR_DAC || a[9:0] == rdtt_pkg::ADDR_REF ||
                   a[9:0] == rdtt_pkg::ADDR_TOUCH || a[9:0] == rdtt_pkg::ADDR_STATUS ||
                   a[9:0] == rdtt_pkg::ADDR_CONVERT);
  endfunction : rdtt_mapped

  logic            conv_s1_r, conv_s2_r, tchk_s1_r, tchk_s2_r;
  logic            dac_power_down_bit_r, dac_power_down_bit_nxt;
  logic            ref_int_r, ref_int_nxt;
  logic [1:0]      reference_settle_delay_r, reference_settle_delay_nxt;
  logic            reference_power_down_r, reference_power_down_nxt;
  logic            ref_vsel_r, ref_vsel_nxt;
  logic [2:0]      pre_r, pre_nxt;
  logic [2:0]      sense_time_field_r, sense_time_field_nxt;
  logic [31:0]     prdata_r, prdata_nxt;
  logic            pready_r, pready_nxt;
  logic            pslverr_r, pslverr_nxt;
  rdtt_ref_t       rst_r, rst_nxt;
  logic [14:0]     rcnt_r, rcnt_nxt;
  logic            ron_r, ron_nxt;
  logic            mrdy_r, mrdy_nxt;
  rdtt_tch_t       tst_r, tst_nxt;
  logic [14:0]     tcnt_r, tcnt_nxt;
  logic            samp_r, samp_nxt;
  logic            wr_en, rd_en, addr_ok;
  logic            ref_want;
  logic [14:0]     settle_cyc;
  logic            dac_en_r, dac_en_nxt;
  logic            pre_act_r, pre_act_nxt;
  logic            sns_act_r, sns_act_nxt;

  // pins come from outside: two stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_s1_r <= 1'b0;
      conv_s2_r <= 1'b0;
      tchk_s1_r <= 1'b0;
      tchk_s2_r <= 1'b0;
    end else begin
      conv_s1_r <= conv_req;
      conv_s2_r <= conv_s1_r;
      tchk_s1_r <= touch_check_req;
      tchk_s2_r <= tchk_s1_r;
    end
  end

  assign addr_ok = rdtt_mapped(paddr);
  // write lands at the edge that completes the transfer
  assign wr_en   = psel && penable && pready_r && pwrite && addr_ok;
  assign rd_en   = psel && penable && !pready_r && !pwrite;

  // apb slave: one wait state, answer in second access cycle
  always_comb begin
    dac_power_down_bit_nxt     = dac_power_down_bit_r;
    ref_int_nxt                = ref_int_r;
    reference_settle_delay_nxt = reference_settle_delay_r;
    reference_power_down_nxt   = reference_power_down_r;
    ref_vsel_nxt               = ref_vsel_r;
    pre_nxt                    = pre_r;
    sense_time_field_nxt       = sense_time_field_r;
    prdata_nxt                 = 32'h0;
    pready_nxt                 = psel && penable && !pready_r;
    pslverr_nxt                = psel && penable && !pready_r && !addr_ok;
    if (wr_en) begin
      case (paddr[9:0])
        rdtt_pkg::ADDR_DAC: begin
          dac_power_down_bit_nxt = pwdata[rdtt_pkg::DAC_PD_BIT];
        end
        rdtt_pkg::ADDR_REF: begin
          ref_int_nxt                = pwdata[rdtt_pkg::INT_BIT];
          reference_settle_delay_nxt = pwdata[rdtt_pkg::SETTLE_LSB +: 2];
          reference_power_down_nxt   = pwdata[rdtt_pkg::REF_PD_BIT];
          ref_vsel_nxt               = pwdata[rdtt_pkg::REF_VSEL_BIT];
        end
        rdtt_pkg::ADDR_TOUCH: begin
          pre_nxt              = pwdata[rdtt_pkg::PRE_LSB +: 3];
          sense_time_field_nxt = pwdata[rdtt_pkg::SENSE_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      case (paddr[9:0])
        rdtt_pkg::ADDR_DAC:
          prdata_nxt[rdtt_pkg::DAC_PD_BIT] = dac_power_down_bit_r;
        rdtt_pkg::ADDR_REF: begin
          prdata_nxt[rdtt_pkg::INT_BIT]       = ref_int_r;
          prdata_nxt[rdtt_pkg::SETTLE_LSB +: 2] = reference_settle_delay_r;
          prdata_nxt[rdtt_pkg::REF_PD_BIT]      = reference_power_down_r;
          prdata_nxt[rdtt_pkg::REF_VSEL_BIT]    = ref_vsel_r;
        end
        rdtt_pkg::ADDR_TOUCH: begin
          prdata_nxt[rdtt_pkg::PRE_LSB +: 3] = pre_r;
          prdata_nxt[rdtt_pkg::SENSE_LSB +: 3] = sense_time_field_r;
        end
        rdtt_pkg::ADDR_STATUS:
          prdata_nxt[3:0] = {samp_r, ron_r, mrdy_r, !dac_power_down_bit_r};
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_power_down_bit_r     <= rdtt_pkg::DAC_PD_RST;
      ref_int_r                <= rdtt_pkg::INT_RST;
      reference_settle_delay_r <= rdtt_pkg::SETTLE_RST;
      reference_power_down_r   <= rdtt_pkg::REF_PD_RST;
      ref_vsel_r               <= rdtt_pkg::REF_VSEL_RST;
      pre_r                    <= rdtt_pkg::PRE_RST;
      sense_time_field_r       <= rdtt_pkg::SENSE_RST;
      prdata_r                 <= 32'h0;
      pready_r                 <= 1'b0;
      pslverr_r                <= 1'b0;
    end else begin
      dac_power_down_bit_r     <= dac_power_down_bit_nxt;
      ref_int_r                <= ref_int_nxt;
      reference_settle_delay_r <= reference_settle_delay_nxt;
      reference_power_down_r   <= reference_power_down_nxt;
      ref_vsel_r               <= ref_vsel_nxt;
      pre_r                    <= pre_nxt;
      sense_time_field_r       <= sense_time_field_nxt;
      prdata_r                 <= prdata_nxt;
      pready_r                 <= pready_nxt;
      pslverr_r                <= pslverr_nxt;
    end
  end

  // reference power sequencing with settle delay
  always_comb begin
    case (reference_settle_delay_r)
      2'b01:   settle_cyc = 15'(rdtt_pkg::SETTLE1_CYC);
      2'b10:   settle_cyc = 15'(rdtt_pkg::SETTLE2_CYC);
      2'b11:   settle_cyc = 15'(rdtt_pkg::SETTLE3_CYC);
      default: settle_cyc = 15'h0;
    endcase
    ref_want = ref_int_r && (!reference_power_down_r || conv_s2_r);
    rst_nxt  = rst_r;
    rcnt_nxt = rcnt_r;
    case (rst_r)
      RDTT_IDLE: begin
        if (ref_want) begin
          rcnt_nxt = settle_cyc;
          rst_nxt  = (settle_cyc == 15'h0) ? RDTT_READY : RDTT_SETTLE;
        end
      end
      RDTT_SETTLE: begin
        if (!ref_want)
          rst_nxt = RDTT_IDLE;
        else if (rcnt_r <= 15'h1)
          rst_nxt = RDTT_READY;
        else
          rcnt_nxt = rcnt_r - 15'h1;
      end
      RDTT_READY: begin
        if (!ref_want)
          rst_nxt = RDTT_IDLE;
      end
      default: rst_nxt = RDTT_IDLE;
    endcase
    ron_nxt  = ref_want;
    // external reference needs no settling
    mrdy_nxt = ref_int_r ? (ref_want && rst_nxt == RDTT_READY) : 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_r  <= RDTT_IDLE;
      rcnt_r <= 15'h0;
      ron_r  <= 1'b0;
      mrdy_r <= 1'b0;
    end else begin
      rst_r  <= rst_nxt;
      rcnt_r <= rcnt_nxt;
      ron_r  <= ron_nxt;
      mrdy_r <= mrdy_nxt;
    end
  end

  // touch check: precharge, then sense wait, then one sample pulse
  always_comb begin
    tst_nxt  = tst_r;
    tcnt_nxt = tcnt_r;
    samp_nxt = 1'b0;
    case (tst_r)
      RDTT_TIDLE: begin
        if (tchk_s2_r) begin
          tcnt_nxt = rdtt_us_cyc(rdtt_pkg::PRE_US[pre_r]);
          tst_nxt  = RDTT_PRE;
        end
      end
      RDTT_PRE: begin
        if (tcnt_r <= 15'h1) begin
          tcnt_nxt = rdtt_us_cyc(rdtt_pkg::SENSE_US[sense_time_field_r]);
          tst_nxt  = RDTT_SNS;
        end else
          tcnt_nxt = tcnt_r - 15'h1;
      end
      RDTT_SNS: begin
        if (tcnt_r <= 15'h1) begin
          samp_nxt = 1'b1;
          tst_nxt  = RDTT_TIDLE;
        end else
          tcnt_nxt = tcnt_r - 15'h1;
      end
      default: tst_nxt = RDTT_TIDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tst_r  <= RDTT_TIDLE;
      tcnt_r <= 15'h0;
      samp_r <= 1'b0;
    end else begin
      tst_r  <= tst_nxt;
      tcnt_r <= tcnt_nxt;
      samp_r <= samp_nxt;
    end
  end

  // pin flags registered from next state so they leave straight from flops
  always_comb begin
    dac_en_nxt  = !dac_power_down_bit_nxt;
    pre_act_nxt = (tst_nxt == RDTT_PRE);
    sns_act_nxt = (tst_nxt == RDTT_SNS);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_en_r  <= !rdtt_pkg::DAC_PD_RST;
      pre_act_r <= 1'b0;
      sns_act_r <= 1'b0;
    end else begin
      dac_en_r  <= dac_en_nxt;
      pre_act_r <= pre_act_nxt;
      sns_act_r <= sns_act_nxt;
    end
  end

  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign dac_enable               = dac_en_r;
  assign dac_current_output_oen   = dac_power_down_bit_r;
  assign reference_internal_on    = ron_r;
  assign reference_input_sel      = ref_int_r;
  assign reference_voltage_select = ref_vsel_r;
  assign meas_ready               = mrdy_r;
  assign precharge_active         = pre_act_r;
  assign sense_active             = sns_act_r;
  assign touch_sample             = samp_r;
endmodule : rdtt_regs
